// ===== verilog/status_clear_pkg.sv
// shared constants for the status clear block
package status_clear_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_STD_EVT  = 8'h00;
    localparam logic [7:0] OFS_OPR_EVT  = 8'h04;
    localparam logic [7:0] OFS_MEAS_EVT = 8'h08;
    localparam logic [7:0] OFS_QUES_EVT = 8'h0c;
    localparam logic [7:0] OFS_STD_ENA  = 8'h10;
    localparam logic [7:0] OFS_OPR_ENA  = 8'h14;
    localparam logic [7:0] OFS_MEAS_ENA = 8'h18;
    localparam logic [7:0] OFS_QUES_ENA = 8'h1c;
    localparam logic [7:0] OFS_CMD      = 8'h20;
    localparam logic [7:0] OFS_ERRQ     = 8'h24;
    localparam logic [7:0] OFS_OUTQ     = 8'h28;
    localparam logic [7:0] OFS_SUMMARY  = 8'h2c;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h30;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h34;
    // command codes written to the command register
    localparam logic [3:0] CMD_NONE       = 4'h0;
    localparam logic [3:0] CMD_CLEAR_EVT  = 4'h1;
    localparam logic [3:0] CMD_STAT_PRE   = 4'h2;
    localparam logic [3:0] CMD_STAT_QCLR  = 4'h3;
    localparam logic [3:0] CMD_SYS_QCLR   = 4'h4;
    localparam logic [3:0] CMD_SYS_PRESET = 4'h5;
    localparam logic [3:0] CMD_DEV_RESET  = 4'h6;
    // summary word field positions
    localparam int SUM_MEAS = 0;
    localparam int SUM_ERR  = 2;
    localparam int SUM_QUES = 3;
    localparam int SUM_MSG  = 4;
    localparam int SUM_STD  = 5;
    localparam int SUM_OPR  = 7;
    // interrupt status bits
    localparam int IRQ_EVT     = 0;
    localparam int IRQ_ERR     = 1;
    localparam int IRQ_CMDDONE = 2;
    localparam logic [2:0] IRQ_RESET = 3'h0;
    localparam logic [15:0] REG_RESET = 16'h0000;
endpackage

// ===== verilog/event_latch.sv
// one sticky event register with clear
`timescale 1ns/100ps
module event_latch #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    input  wire logic             clkEn,
    // events and clear
    input  wire logic [WIDTH-1:0] eventIn,
    input  wire logic             clear,
    // state
    output logic      [WIDTH-1:0] bits
);
    logic [WIDTH-1:0] bits_q;
    logic [WIDTH-1:0] bits_d;
    // a new event in the clearing cycle survives
    assign bits_d = (clear ? '0 : bits_q) | eventIn;
    always_ff @(posedge clk_sys) begin
        if (sys_rst)
            bits_q <= '0;
        else if (clkEn)
            bits_q <= bits_d;
    end
    assign bits = bits_q;

    property p_sticky;
        @(posedge clk_sys) disable iff (sys_rst)
        clkEn && !clear && bits_q != '0 |=> (bits_q & $past(bits_q)) == $past(bits_q);
    endproperty
    a_sticky: assert property (p_sticky) else $error("event bit lost");
endmodule

// ===== verilog/error_queue.sv
// small error message queue with flush
`timescale 1ns/100ps
module error_queue #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    input  wire logic             clkEn,
    // push side
    input  wire logic             pushValid,
    input  wire logic [WIDTH-1:0] pushData,
    // pop side
    input  wire logic             pop,
    input  wire logic             flush,
    output logic      [WIDTH-1:0] headData,
    output logic                  notEmpty,
    output logic                  overflow
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic [WIDTH-1:0] head_q;
    wire  full     = (cnt_q == (AW+1)'(DEPTH));
    wire  doPop    = pop && cnt_q != '0;
    wire  doPush   = pushValid && !full;
    // a full queue drops new messages and flags it
    assign overflow = pushValid && full;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else if (clkEn) begin
            if (flush) begin
                wr_q  <= '0;
                rd_q  <= '0;
                cnt_q <= '0;
            end else begin
                if (doPush)
                    wr_q <= AW'(wr_q + 1'b1);
                if (doPop)
                    rd_q <= AW'(rd_q + 1'b1);
                cnt_q <= (AW+1)'(cnt_q + doPush - doPop);
            end
        end
    end
    always_ff @(posedge clk_sys) begin
        if (clkEn && doPush && !flush)
            mem[wr_q] <= pushData;
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst)
            head_q <= '0;
        else if (clkEn)
            head_q <= (cnt_q == '0) ? '0 : mem[rd_q];
    end
    assign headData = head_q;
    assign notEmpty = cnt_q != '0;

    property p_flush;
        @(posedge clk_sys) disable iff (sys_rst)
        clkEn && flush |=> cnt_q == '0;
    endproperty
    a_flush: assert property (p_flush) else $error("queue not emptied");
endmodule

// ===== verilog/status_clear_logic.sv
// status register set clear and reset logic with wishbone slave
// What this block does
// - everything zero and error queue empty after reset
// - writing zero to an enable clears it
// - preset and device reset leave status alone
// - event clear zeroes all four event registers
// - status preset zeroes three enable registers
// - standard enable survives preset and event clear
// - status preset keeps error queue contents
// - two distinct commands each flush error queue
// - event bits stick until explicitly cleared
// - reading standard events clears them
//
// The Wishbone slave port and the placing of the registers were decided locally.
`timescale 1ns/100ps
module status_clear_logic #(
    parameter int WIDTH   = 16,
    parameter int Q_DEPTH = 8
) (
    // clock, reset, enable
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    input  wire logic             clkEn,
    // wishbone slave
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [7:0]       wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    output logic                  wb_err_o,
    // instrument events
    input  wire logic [WIDTH-1:0] stdEvent,
    input  wire logic [WIDTH-1:0] oprEvent,
    input  wire logic [WIDTH-1:0] measEvent,
    input  wire logic [WIDTH-1:0] quesEvent,
    // error messages
    input  wire logic             errPush,
    input  wire logic [WIDTH-1:0] errData,
    // output queue level
    input  wire logic             outQueueNotEmpty,
    output logic                  outQueueClear,
    // command pulses to the rest of the instrument
    output logic                  sysPresetPulse,
    output logic                  devResetPulse,
    // summaries and interrupt
    output logic      [7:0]       summary,
    output logic                  irq
);
    typedef enum logic [1:0] {IDLE, EXEC, DONE} cmd_state_e;
    cmd_state_e state_q;
    cmd_state_e state_d;

    logic [WIDTH-1:0] stdEna_q;
    logic [WIDTH-1:0] oprEna_q;
    logic [WIDTH-1:0] measEna_q;
    logic [WIDTH-1:0] quesEna_q;
    logic [3:0]       cmd_q;
    logic             ack_q;
    logic             err_q;
    logic [31:0]      rdat_q;
    logic [2:0]       irqStat_q;
    logic [2:0]       irqMask_q;
    logic             stdPrev_q;
    logic             errPrev_q;
    logic             sysPre_q;
    logic             devRst_q;

    wire [WIDTH-1:0] stdBits;
    wire [WIDTH-1:0] oprBits;
    wire [WIDTH-1:0] measBits;
    wire [WIDTH-1:0] quesBits;
    wire [WIDTH-1:0] errHead;
    wire             errNotEmpty;
    wire             errOverflow;

    // bus decode: a request is served once, ack drops the next cycle
    wire req      = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
    // commands are held off while one is in flight
    wire busy     = state_q != IDLE;
    wire wrLow    = wb_sel_i[0];
    wire wrHigh   = wb_sel_i[1];
    wire hitStdEv = wb_adr_i == status_clear_pkg::OFS_STD_EVT;
    wire hitOprEv = wb_adr_i == status_clear_pkg::OFS_OPR_EVT;
    wire hitMeaEv = wb_adr_i == status_clear_pkg::OFS_MEAS_EVT;
    wire hitQueEv = wb_adr_i == status_clear_pkg::OFS_QUES_EVT;
    wire hitStdEn = wb_adr_i == status_clear_pkg::OFS_STD_ENA;
    wire hitOprEn = wb_adr_i == status_clear_pkg::OFS_OPR_ENA;
    wire hitMeaEn = wb_adr_i == status_clear_pkg::OFS_MEAS_ENA;
    wire hitQueEn = wb_adr_i == status_clear_pkg::OFS_QUES_ENA;
    wire hitCmd   = wb_adr_i == status_clear_pkg::OFS_CMD;
    wire hitErrQ  = wb_adr_i == status_clear_pkg::OFS_ERRQ;
    wire hitOutQ  = wb_adr_i == status_clear_pkg::OFS_OUTQ;
    wire hitSum   = wb_adr_i == status_clear_pkg::OFS_SUMMARY;
    wire hitIStat = wb_adr_i == status_clear_pkg::OFS_IRQ_STAT;
    wire hitIMask = wb_adr_i == status_clear_pkg::OFS_IRQ_MASK;
    wire mapped   = hitStdEv | hitOprEv | hitMeaEv | hitQueEv | hitStdEn | hitOprEn
                  | hitMeaEn | hitQueEn | hitCmd | hitErrQ | hitOutQ | hitSum
                  | hitIStat | hitIMask;
    // a command write while busy is refused with an error cycle
    wire cmdRefuse = req && wb_we_i && hitCmd && busy;
    wire accept    = req && mapped && !cmdRefuse;
    wire wrAcc     = accept && wb_we_i;
    wire rdAcc     = accept && !wb_we_i;
    wire cmdWrite  = wrAcc && hitCmd && wrLow;
    wire [3:0] newCmd = wb_dat_i[3:0];

    // command decode while executing
    wire execNow   = state_q == EXEC;
    wire doEvClr   = execNow && cmd_q == status_clear_pkg::CMD_CLEAR_EVT;
    wire doStatPre = execNow && cmd_q == status_clear_pkg::CMD_STAT_PRE;
    wire doQFlush  = execNow && (cmd_q == status_clear_pkg::CMD_STAT_QCLR
                              || cmd_q == status_clear_pkg::CMD_SYS_QCLR);
    wire doSysPre  = execNow && cmd_q == status_clear_pkg::CMD_SYS_PRESET;
    wire doDevRst  = execNow && cmd_q == status_clear_pkg::CMD_DEV_RESET;
    // reading the standard event register empties it
    wire stdRdClr  = rdAcc && hitStdEv;
    wire errPop    = rdAcc && hitErrQ;

    event_latch #(.WIDTH(WIDTH)) u_std (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(clkEn),
        .eventIn(stdEvent), .clear(doEvClr || stdRdClr), .bits(stdBits));
    event_latch #(.WIDTH(WIDTH)) u_opr (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(clkEn),
        .eventIn(oprEvent), .clear(doEvClr), .bits(oprBits));
    event_latch #(.WIDTH(WIDTH)) u_meas (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(clkEn),
        .eventIn(measEvent), .clear(doEvClr), .bits(measBits));
    event_latch #(.WIDTH(WIDTH)) u_ques (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(clkEn),
        .eventIn(quesEvent), .clear(doEvClr), .bits(quesBits));

    // preset leaves the queue untouched: only the two flush commands reach it
    error_queue #(.WIDTH(WIDTH), .DEPTH(Q_DEPTH)) u_errq (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(clkEn),
        .pushValid(errPush), .pushData(errData),
        .pop(errPop), .flush(doQFlush),
        .headData(errHead), .notEmpty(errNotEmpty), .overflow(errOverflow));

    // command sequencer: one cycle to execute, one to settle
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            IDLE: if (cmdWrite && newCmd != status_clear_pkg::CMD_NONE) state_d = EXEC;
            EXEC: state_d = DONE;
            DONE: state_d = IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_q <= IDLE;
            cmd_q   <= status_clear_pkg::CMD_NONE;
        end else if (clkEn) begin
            state_q <= state_d;
            if (state_q == IDLE && cmdWrite)
                cmd_q <= newCmd;
        end
    end

    // enable registers: standard enable only moves by its own write
    wire [WIDTH-1:0] wmask = {{(WIDTH-8){wrHigh}}, {8{wrLow}}};
    wire [WIDTH-1:0] wval  = wb_dat_i[WIDTH-1:0];
    function automatic logic [WIDTH-1:0] merge(input logic [WIDTH-1:0] old);
        merge = (old & ~wmask) | (wval & wmask);
    endfunction

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            stdEna_q  <= status_clear_pkg::REG_RESET;
            oprEna_q  <= status_clear_pkg::REG_RESET;
            measEna_q <= status_clear_pkg::REG_RESET;
            quesEna_q <= status_clear_pkg::REG_RESET;
        end else if (clkEn) begin
            if (wrAcc && hitStdEn)
                stdEna_q <= merge(stdEna_q);
            if (doStatPre)
                oprEna_q <= status_clear_pkg::REG_RESET;
            else if (wrAcc && hitOprEn)
                oprEna_q <= merge(oprEna_q);
            if (doStatPre)
                measEna_q <= status_clear_pkg::REG_RESET;
            else if (wrAcc && hitMeaEn)
                measEna_q <= merge(measEna_q);
            if (doStatPre)
                quesEna_q <= status_clear_pkg::REG_RESET;
            else if (wrAcc && hitQueEn)
                quesEna_q <= merge(quesEna_q);
        end
    end

    // summaries are live, not latched, so a read clear drops them at once
    wire [7:0] sumLive;
    assign sumLive[status_clear_pkg::SUM_MEAS] = |(measBits & measEna_q);
    assign sumLive[1]                          = 1'b0;
    assign sumLive[status_clear_pkg::SUM_ERR]  = errNotEmpty;
    assign sumLive[status_clear_pkg::SUM_QUES] = |(quesBits & quesEna_q);
    assign sumLive[status_clear_pkg::SUM_MSG]  = outQueueNotEmpty;
    assign sumLive[status_clear_pkg::SUM_STD]  = |(stdBits & stdEna_q);
    assign sumLive[6]                          = 1'b0;
    assign sumLive[status_clear_pkg::SUM_OPR]  = |(oprBits & oprEna_q);

    // interrupt sources: rising standard summary, new error, command finished
    wire [2:0] irqSet;
    assign irqSet[status_clear_pkg::IRQ_EVT]     = sumLive[status_clear_pkg::SUM_STD] && !stdPrev_q;
    assign irqSet[status_clear_pkg::IRQ_ERR]     = (errNotEmpty && !errPrev_q) || errOverflow;
    assign irqSet[status_clear_pkg::IRQ_CMDDONE] = state_q == DONE;
    wire [2:0] irqClr = (wrAcc && hitIStat && wrLow) ? wb_dat_i[2:0] : 3'h0;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            irqStat_q <= status_clear_pkg::IRQ_RESET;
            irqMask_q <= status_clear_pkg::IRQ_RESET;
            stdPrev_q <= 1'b0;
            errPrev_q <= 1'b0;
        end else if (clkEn) begin
            irqStat_q <= (irqStat_q & ~irqClr) | irqSet;
            if (wrAcc && hitIMask && wrLow)
                irqMask_q <= wb_dat_i[2:0];
            stdPrev_q <= sumLive[status_clear_pkg::SUM_STD];
            errPrev_q <= errNotEmpty;
        end
    end

    // read mux; bits above the register width read zero
    wire [31:0] rdMux =
          hitStdEv ? 32'(stdBits)  : hitOprEv ? 32'(oprBits)   : hitMeaEv ? 32'(measBits)
        : hitQueEv ? 32'(quesBits) : hitStdEn ? 32'(stdEna_q)  : hitOprEn ? 32'(oprEna_q)
        : hitMeaEn ? 32'(measEna_q): hitQueEn ? 32'(quesEna_q)
        : hitCmd   ? {30'h0, busy, 1'b0} | 32'({cmd_q, 2'b00}) : hitErrQ ? 32'(errHead)
        : hitOutQ  ? {31'h0, outQueueNotEmpty} : hitSum ? {24'h0, sumLive}
        : hitIStat ? {29'h0, irqStat_q} : hitIMask ? {29'h0, irqMask_q} : 32'h0;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ack_q    <= 1'b0;
            err_q    <= 1'b0;
            rdat_q   <= 32'h0;
            sysPre_q <= 1'b0;
            devRst_q <= 1'b0;
        end else if (clkEn) begin
            ack_q    <= accept;
            err_q    <= req && !accept;
            if (rdAcc)
                rdat_q <= rdMux;
            // these only signal the rest of the instrument
            sysPre_q <= doSysPre;
            devRst_q <= doDevRst;
        end
    end

    assign wb_ack_o       = ack_q;
    assign wb_err_o       = err_q;
    assign wb_dat_o       = rdat_q;
    assign outQueueClear  = 1'b0;
    assign sysPresetPulse = sysPre_q;
    assign devResetPulse  = devRst_q;
    assign summary        = sumLive;
    assign irq            = |(irqStat_q & irqMask_q);

    // assertions
    sequence s_cmd_run;
        state_q == EXEC ##1 state_q == DONE ##1 state_q == IDLE;
    endsequence
    property p_done;
        @(posedge clk_sys) disable iff (sys_rst || !clkEn)
        state_q == IDLE && state_d == EXEC |=> s_cmd_run;
    endproperty
    a_done: assert property (p_done) else $error("sequencer broken");
    property p_seq;
        @(posedge clk_sys) disable iff (sys_rst)
        $rose(state_q == EXEC) && clkEn ##1 clkEn |-> ##0 state_q == DONE;
    endproperty
    a_seq: assert property (p_seq) else $error("command not finished in time");
    property p_evclr;
        @(posedge clk_sys) disable iff (sys_rst)
        clkEn && doEvClr && oprEvent == '0 && measEvent == '0 && quesEvent == '0
        |=> oprBits == '0 && measBits == '0 && quesBits == '0;
    endproperty
    a_evclr: assert property (p_evclr) else $error("event registers not cleared");
    property p_preset;
        @(posedge clk_sys) disable iff (sys_rst)
        clkEn && doStatPre |=> oprEna_q == '0 && measEna_q == '0 && quesEna_q == '0;
    endproperty
    a_preset: assert property (p_preset) else $error("enables not preset");
    property p_stdena;
        @(posedge clk_sys) disable iff (sys_rst)
        clkEn && !(wrAcc && hitStdEn) |=> $stable(stdEna_q);
    endproperty
    a_stdena: assert property (p_stdena) else $error("standard enable moved");
    property p_zero;
        @(posedge clk_sys) disable iff (sys_rst)
        clkEn && wrAcc && hitOprEn && !doStatPre && wval == '0 && wmask == '1
        |=> oprEna_q == '0;
    endproperty
    a_zero: assert property (p_zero) else $error("zero write did not clear");
    property p_keepq;
        @(posedge clk_sys) disable iff (sys_rst)
        clkEn && (doStatPre || doSysPre || doDevRst) && errNotEmpty && !errPop
        |=> errNotEmpty;
    endproperty
    a_keepq: assert property (p_keepq) else $error("queue lost on preset");
    property p_rdclr;
        @(posedge clk_sys) disable iff (sys_rst)
        clkEn && stdRdClr && stdEvent == '0
        |=> stdBits == '0 && !summary[status_clear_pkg::SUM_STD];
    endproperty
    a_rdclr: assert property (p_rdclr) else $error("read did not clear");
    property p_qflush;
        @(posedge clk_sys) disable iff (sys_rst)
        clkEn && doQFlush |=> !errNotEmpty;
    endproperty
    a_qflush: assert property (p_qflush) else $error("queue not flushed");
    property p_reset;
        @(posedge clk_sys) $fell(sys_rst) |-> stdEna_q == '0 && !errNotEmpty && stdBits == '0;
    endproperty
    a_reset: assert property (p_reset) else $error("not clear after reset");
    property p_evset;
        @(posedge clk_sys) disable iff (sys_rst)
        clkEn && oprEvent != '0 |=> (oprBits & $past(oprEvent)) == $past(oprEvent);
    endproperty
    a_evset: assert property (p_evset) else $error("event bit not set");
    property p_stdclr;
        @(posedge clk_sys) disable iff (sys_rst)
        clkEn && doEvClr && stdEvent == '0 |=> stdBits == '0;
    endproperty
    a_stdclr: assert property (p_stdclr) else $error("standard events not cleared");
    property p_keepstd;
        @(posedge clk_sys) disable iff (sys_rst)
        clkEn && (doStatPre || doEvClr) && !(wrAcc && hitStdEn) |=> $stable(stdEna_q);
    endproperty
    a_keepstd: assert property (p_keepstd) else $error("standard enable preset");
    property p_noeffect;
        @(posedge clk_sys) disable iff (sys_rst)
        clkEn && (doSysPre || doDevRst) && !wrAcc |=> $stable({oprEna_q, measEna_q, quesEna_q});
    endproperty
    a_noeffect: assert property (p_noeffect) else $error("enables moved");
    property p_zeroq;
        @(posedge clk_sys) disable iff (sys_rst)
        clkEn && wrAcc && hitQueEn && !doStatPre && wval == '0 && wmask == '1
        |=> quesEna_q == '0;
    endproperty
    a_zeroq: assert property (p_zeroq) else $error("zero write kept bits");
endmodule

// ===== sim/ctrl_model.sv
// remote controller model issuing classic wishbone cycles
`timescale 1ns/100ps
module ctrl_model (
    // clock
    input  wire logic        clk_sys,
    // wishbone master side
    output logic             cyc,
    output logic             stb,
    output logic             we,
    output logic [7:0]       adr,
    output logic [3:0]       sel,
    output logic [31:0]      dat,
    input  wire logic [31:0] datIn,
    input  wire logic        ack,
    input  wire logic        err
);
    initial begin
        cyc = 1'b0;
        stb = 1'b0;
        we  = 1'b0;
        adr = 8'hff;
        sel = 4'h0;
        dat = 32'h0;
    end
    // hang reports a missing answer; the bench owns the verdict
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e, output logic hang);
        int n;
        n = 0;
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= wr;
        adr <= a;
        sel <= 4'h3;
        dat <= d;
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
        q = datIn;
        e = err;
        hang = (ack !== 1'b1 && err !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        // released lines show a changed value so stale data never looks valid
        adr <= ~a;
        dat <= ~d;
    endtask
endmodule

// ===== sim/tb_top.sv
// self-checking bench for the status clear block
`timescale 1ns/100ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin mismatches++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module tb_top;
    logic        clk_sys;
    logic        sys_rst;
    logic        clkEn;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] datW;
    logic [31:0] datR;
    logic        ack;
    logic        err;
    logic [15:0] stdEvent;
    logic [15:0] oprEvent;
    logic [15:0] measEvent;
    logic [15:0] quesEvent;
    logic        errPush;
    logic [15:0] errData;
    logic        outQueueNotEmpty;
    logic        outQueueClear;
    logic        sysPresetPulse;
    logic        devResetPulse;
    logic [7:0]  summary;
    logic        irq;
    int          mismatches;
    int          comparisons;
    int          presets = 0;
    int          devResets = 0;

    status_clear_logic DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(clkEn),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack), .wb_err_o(err),
        .stdEvent(stdEvent), .oprEvent(oprEvent), .measEvent(measEvent),
        .quesEvent(quesEvent), .errPush(errPush), .errData(errData),
        .outQueueNotEmpty(outQueueNotEmpty), .outQueueClear(outQueueClear),
        .sysPresetPulse(sysPresetPulse), .devResetPulse(devResetPulse),
        .summary(summary), .irq(irq));
    ctrl_model host (.clk_sys(clk_sys), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
        .sel(sel), .dat(datW), .datIn(datR), .ack(ack), .err(err));

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // count command pulses towards the rest of the instrument
    always @(posedge clk_sys) begin
        if (sysPresetPulse) presets <= presets + 1;
        if (devResetPulse) devResets <= devResets + 1;
    end

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        logic hang;
        host.xfer(w, a, d, q, e, hang);
        if (hang) begin
            mismatches++;
            close_out();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic expErr = 1'b0);
        logic [31:0] q;
        logic        e;
        bus(1'b1, a, d, q, e);
        `CHK(e, expErr)
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        bus(1'b0, a, 32'h0, q, e);
        `CHK(q, exp)
    endtask
    // busy lasts two cycles after a command is taken
    task automatic cmd(input logic [3:0] c);
        wr(status_clear_pkg::OFS_CMD, {28'h0, c});
        repeat (2) @(posedge clk_sys);
    endtask
    task automatic evt(input logic [15:0] s, input logic [15:0] o, input logic [15:0] m,
                       input logic [15:0] qv);
        @(posedge clk_sys);
        stdEvent <= s;
        oprEvent <= o;
        measEvent <= m;
        quesEvent <= qv;
        @(posedge clk_sys);
        {stdEvent, oprEvent, measEvent, quesEvent} <= 64'h0;
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic push(input logic [15:0] d);
        @(posedge clk_sys);
        errPush <= 1'b1;
        errData <= d;
        @(posedge clk_sys);
        errPush <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask

    task automatic t_reset();
        for (int i = 0; i < 14; i++) rd(8'(4 * i), 32'h0);
        `CHK(summary, 8'h00)
        `CHK(irq, 1'b0)
        $display("t_reset done");
    endtask
    task automatic t_enable();
        for (int i = 0; i < 4; i++) begin
            wr(8'h10 + 8'(4 * i), 32'hffff);
            rd(8'h10 + 8'(4 * i), 32'hffff);
            wr(8'h10 + 8'(4 * i), 32'h0);
            rd(8'h10 + 8'(4 * i), 32'h0);
        end
        $display("t_enable done");
    endtask
    task automatic t_commands();
        for (int i = 0; i < 4; i++) wr(8'h10 + 8'(4 * i), 32'hffff);
        evt(16'h0011, 16'h0102, 16'h2004, 16'h8000);
        push(16'h00aa);
        push(16'h00bb);
        for (int c = 5; c < 7; c++) begin
            cmd(4'(c));
            rd(8'h04, 32'h0102);
            rd(8'h08, 32'h2004);
            rd(8'h0c, 32'h8000);
            rd(8'h1c, 32'hffff);
            `CHK(summary, 8'had)
            `CHK(outQueueClear, 1'b0)
            `CHK(presets, 1)
            `CHK(devResets, c - 5)
        end
        cmd(4'h2);
        rd(8'h14, 32'h0);
        rd(8'h18, 32'h0);
        rd(8'h1c, 32'h0);
        rd(8'h10, 32'hffff);
        rd(8'h04, 32'h0102);
        `CHK(summary, 8'h24)
        rd(8'h24, 32'h00aa);
        cmd(4'h1);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h0);
        rd(8'h0c, 32'h0);
        rd(8'h00, 32'h0);
        rd(8'h10, 32'hffff);
        `CHK(summary, 8'h04)
        cmd(4'h3);
        `CHK(summary, 8'h00)
        push(16'h00cc);
        `CHK(summary, 8'h04)
        cmd(4'h4);
        `CHK(summary, 8'h00)
        $display("t_commands done");
    endtask
    task automatic t_readclr();
        evt(16'h0004, 16'h0, 16'h0, 16'h0);
        `CHK(summary, 8'h20)
        rd(8'h00, 32'h0004);
        @(posedge clk_sys);
        `CHK(summary, 8'h00)
        rd(8'h00, 32'h0);
        outQueueNotEmpty <= 1'b1;
        repeat (2) @(posedge clk_sys);
        `CHK(summary, 8'h10)
        rd(8'h28, 32'h1);
        outQueueNotEmpty <= 1'b0;
        $display("t_readclr done");
    endtask
    task automatic t_irq();
        wr(8'h34, 32'h0);
        wr(8'h30, 32'h7);
        rd(8'h30, 32'h0);
        cmd(4'h1);
        rd(8'h30, 32'h4);
        `CHK(irq, 1'b0)
        wr(8'h34, 32'h4);
        @(posedge clk_sys);
        `CHK(irq, 1'b1)
        wr(8'h30, 32'h4);
        @(posedge clk_sys);
        `CHK(irq, 1'b0)
        wr(8'h40, 32'h1234, 1'b1);
        $display("t_irq done");
    endtask

    initial begin
        mismatches = 0;
        comparisons = 0;
        sys_rst = 1'b1;
        clkEn = 1'b1;
        {stdEvent, oprEvent, measEvent, quesEvent} = 64'h0;
        errPush = 1'b0;
        errData = 16'h0;
        outQueueNotEmpty = 1'b0;
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_reset();
        t_enable();
        t_commands();
        t_readclr();
        t_irq();
        close_out();
    end
endmodule
